/* tb/tb_tms_sequencer.sv */
// Purpose: Self-checking bench of the touch digitizer sequencer
// Assumes: Comparator modelled against a fixed analog level
// Notes: Serial frames come from the host model
module tb_tms_sequencer
   import tms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] ID_VAL = 12'h3C5; // Arbitrary value
   localparam logic [11:0] AV = 12'hA6B; // Analog level as a code
   logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmp_hi;
   logic [7:0] wb_adr_i, rise_no;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic cs_n_pin, serial_conv_clock, din_pin, dout, dout_oe_n;
   logic busy_o, busy_oe_n, track_o, x_drv_on, y_drv_on, pwr_down;
   logic [11:0] sar_trial;
   tms_mux_e mux_sel;
   tms_ref_e ref_sel;
   int mismatches = 0, n_tests = 0, cyc_cnt = 0;
   always #12.5 clk_sys = ~clk_sys;
   // Ideal comparator: result code equals the analog level
   always @(posedge clk_sys) cmp_hi <= (AV >= sar_trial);
   tms_sequencer #(.IDENT_CODE(ID_VAL)) tms_sequencer_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .cs_n_pin(cs_n_pin),
      .serial_conv_clock(serial_conv_clock), .din_pin(din_pin),
      .cmp_hi(cmp_hi), .sar_trial(sar_trial), .dout(dout),
      .dout_oe_n(dout_oe_n), .busy_o(busy_o), .busy_oe_n(busy_oe_n),
      .track_o(track_o), .mux_sel(mux_sel), .ref_sel(ref_sel),
      .x_drv_on(x_drv_on), .y_drv_on(y_drv_on), .pwr_down(pwr_down));
   tms_host_model #(.H(8)) tms_host_model_inst (
      .clk_sys(clk_sys), .cs_n_pin(cs_n_pin),
      .serial_conv_clock(serial_conv_clock), .din_pin(din_pin),
      .rise_no(rise_no), .dout(dout));
   // ----------
   // Reporting
   // ----------
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %b", $time, msg, got);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Hang guard: frames take about 700 cycles each
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         mismatches++;
         $display("[FAIL] %0t timeout", $time);
         results();
      end
   end
   // ----------
   // Bus and frame tasks
   // ----------
   // Classic cycle: hold everything until ack is sampled
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // One conversion; mx 7 skips the decode checks
   task automatic run_case(input logic [7:0] cmd, input logic [11:0] exp,
         input logic [2:0] mx, input logic [1:0] rf, xy);
      logic [39:0] cap;
      logic [11:0] got;
      int first;
      logic idc;
      // Identity skips conversion and leaves right after the hold edge
      idc = (cmd[6:4] == TMS_CH_AUXB) && !cmd[2];
      first = idc ? 9 : (cmd[3] ? 16 : 20); // 8-bit four rises sooner
      fork
         tms_host_model_inst.frame(cmd, 3, 40, cap);
         begin
            wait (rise_no == 8'd4);
            chk_bit(track_o, 1'b0, "track early");
            wait (rise_no == 8'd7);
            chk_bit(track_o, 1'b1, "track");
            wait (rise_no == 8'd11);
            chk_bit(track_o, 1'b0, "track end");
            chk_bit(busy_o, !idc, "busy");
            if (mx != 3'h7) begin
               chk_word({29'h0, mux_sel}, {29'h0, mx}, "mux");
               chk_word({30'h0, ref_sel}, {30'h0, rf}, "ref");
               chk_word({30'h0, x_drv_on, y_drv_on}, {30'h0, xy},
                  "drv");
            end
         end
      join
      for (int i = 0; i < 12; i++) got[11-i] = cap[first+i];
      chk_word({20'h0, got}, {20'h0, exp}, "result");
      chk_word({29'h0, cap[first+12 +: 3]}, 32'h0, "tail");
      repeat (6) @(posedge clk_sys);
      chk_bit(dout_oe_n, 1'b1, "oe off");
   endtask
   // ----------
   // Main sequence
   // ----------
   initial begin
      logic [31:0] rd;
      logic [39:0] cap;
      clk_sys = 1'b0;
      rst_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, cmp_hi} = 4'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk_bit(pwr_down, 1'b1, "reset power");
      chk_bit(dout_oe_n, 1'b1, "reset oe");
      wb_xfer(1'b0, TMS_OFF_CFG, 32'h0, rd);
      chk_word(rd, 32'h1, "cfg reset");
      wb_xfer(1'b1, TMS_OFF_CFG, 32'h0, rd);
      wb_xfer(1'b0, TMS_OFF_CFG, 32'h0, rd);
      chk_word(rd, 32'h0, "cfg off");
      wb_xfer(1'b1, TMS_OFF_CFG, 32'h1, rd);
      wb_xfer(1'b1, TMS_OFF_IDENT, 32'h0, rd);
      wb_xfer(1'b0, TMS_OFF_IDENT, 32'h0, rd);
      chk_word(rd, {20'h0, ID_VAL}, "ident reg");
      wb_xfer(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
      wb_xfer(1'b0, 8'h40, 32'h0, rd);
      chk_word(rd, 32'h0, "unmapped");
      // Word cut short by deselect, then full frames of valid codes
      tms_host_model_inst.frame(8'h94, 0, 4, cap);
      repeat (6) @(posedge clk_sys);
      chk_bit(dout_oe_n, 1'b1, "abort oe");
      run_case(8'h94, AV, 3'h1, 2'h0, 2'b01);
      chk_bit(pwr_down, 1'b1, "sleep");
      run_case(8'hAC, {AV[11:4], 4'h0}, 3'h3, 2'h0, 2'b00);
      run_case(8'hD7, AV, 3'h2, 2'h0, 2'b10);
      chk_bit(x_drv_on, 1'b1, "drv kept");
      chk_bit(pwr_down, 1'b0, "awake");
      run_case(8'hE4, AV, 3'h4, 2'h0, 2'b00);
      chk_bit(pwr_down, 1'b1, "sleep again");
      run_case(8'h90, AV, 3'h1, 2'h1, 2'b01);
      run_case(8'hD0, AV, 3'h2, 2'h2, 2'b10);
      chk_bit(x_drv_on, 1'b0, "drv off");
      run_case(8'hE0, ID_VAL, 3'h7, 2'h0, 2'b00);
      results();
   end
endmodule

/* tb/tms_host_model.sv */
// Purpose: Host serial port that frames commands and reads results
// Assumes: clk_sys paces the serial clock, half period H cycles
// Notes: Serial clock idles low outside frames
module tms_host_model #(
   parameter int H = 8 // Slow clock leaves settling time
) (
   input wire logic clk_sys,
   output logic cs_n_pin,
   output logic serial_conv_clock,
   output logic din_pin,
   output logic [7:0] rise_no,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n_pin = 1'b1;
      serial_conv_clock = 1'b0;
      din_pin = 1'b0;
      rise_no = 8'hFF;
   end
   // Released data line toggles so a stale bit never looks valid
   always @(posedge clk_sys) begin
      if (cs_n_pin) begin
         din_pin <= ~din_pin;
      end
   end
   // Lead zeros, command MSB first, dout sampled at each rise after the lead
   task automatic frame(input logic [7:0] cmd, input int lead,
         input int nrise, output logic [39:0] cap);
      int k;
      cap = '0;
      @(posedge clk_sys);
      cs_n_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (k = -lead; k < nrise; k++) begin
         din_pin <= (k >= 0 && k < 8) ? cmd[7-k] : 1'b0;
         repeat (H) @(posedge clk_sys);
         serial_conv_clock <= 1'b1;
         if (k >= 0) begin
            cap[k] = dout;
            rise_no = 8'(k);
         end
         repeat (H) @(posedge clk_sys);
         serial_conv_clock <= 1'b0;
      end
      @(posedge clk_sys);
      cs_n_pin <= 1'b1;
      rise_no = 8'hFF;
   endtask
endmodule

/* tb/tms_sequencer_properties.sv */
// Purpose: Port checks of the touch digitizer sequencer
// Assumes: Serial half period is at least 8 clk_sys cycles
// Notes: Bound into every tms_sequencer instance
module tms_sequencer_properties
   import tms_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic cs_n_pin,
   input wire logic serial_conv_clock,
   input wire logic [11:0] sar_trial,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic busy_o,
   input wire logic busy_oe_n,
   input wire logic track_o,
   input wire tms_mux_e mux_sel,
   input wire tms_ref_e ref_sel,
   input wire logic x_drv_on,
   input wire logic y_drv_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Helper
   // ----------
   logic sclk_q; // Serial clock one cycle late
   logic [3:0] fall_age_q; // Cycles since the serial clock fell
   // Saturates, so an old fall never wraps back into range
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         fall_age_q <= 4'hF;
      end else begin
         sclk_q <= serial_conv_clock;
         if (sclk_q && !serial_conv_clock) begin
            fall_age_q <= 4'h0;
         end else if (fall_age_q != 4'hF) begin
            fall_age_q <= fall_age_q + 4'h1;
         end
      end
   end
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_desel;
      cs_n_pin [*6];
   endsequence
   sequence s_still;
      ($stable(serial_conv_clock) && $stable(cs_n_pin)) [*8];
   endsequence
   property p_ack;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   property p_sclk_only;
      s_still |-> $stable(sar_trial);
   endproperty
   property p_dout_fall;
      $changed(dout) && !dout_oe_n && !$past(dout_oe_n)
         |-> fall_age_q < 4'h8;
   endproperty
   property p_hiz;
      s_desel |-> dout_oe_n && busy_oe_n;
   endproperty
   property p_track_first;
      track_o |-> !busy_o;
   endproperty
   property p_conv_after;
      // Identity words select no input and skip the conversion
      $fell(track_o) && !cs_n_pin && mux_sel != TMS_MUX_NONE
         |-> ##[0:24] busy_o;
   endproperty
   property p_aux_off;
      mux_sel inside {TMS_MUX_AUXA, TMS_MUX_AUXB}
         |-> !x_drv_on && !y_drv_on && ref_sel == TMS_REF_PIN;
   endproperty
   property p_ypair;
      ref_sel == TMS_REF_YPAIR |-> mux_sel == TMS_MUX_XP && !x_drv_on;
   endproperty
   property p_xpair;
      ref_sel == TMS_REF_XPAIR |-> mux_sel == TMS_MUX_YP && !y_drv_on;
   endproperty
   property p_one_pair;
      x_drv_on |-> !y_drv_on;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not a single cycle after request");
   a_sclk_only: assert property (p_sclk_only)
      else $error("trial code moved without serial clock");
   a_dout_fall: assert property (p_dout_fall)
      else $error("dout changed away from a falling edge");
   a_hiz: assert property (p_hiz)
      else $error("outputs driven while deselected");
   a_track_first: assert property (p_track_first)
      else $error("busy during acquisition");
   a_conv_after: assert property (p_conv_after)
      else $error("no conversion after tracking");
   a_aux_off: assert property (p_aux_off)
      else $error("aux channel with drivers or pair reference");
   a_ypair: assert property (p_ypair)
      else $error("Y pair reference without X+ input");
   a_xpair: assert property (p_xpair)
      else $error("X pair reference without Y+ input");
   a_one_pair: assert property (p_one_pair)
      else $error("both panel pairs driven");
endmodule

bind tms_sequencer tms_sequencer_properties chk_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n_pin(cs_n_pin),
   .serial_conv_clock(serial_conv_clock), .sar_trial(sar_trial),
   .dout(dout), .dout_oe_n(dout_oe_n), .busy_o(busy_o),
   .busy_oe_n(busy_oe_n), .track_o(track_o), .mux_sel(mux_sel),
   .ref_sel(ref_sel), .x_drv_on(x_drv_on), .y_drv_on(y_drv_on)
);

/* verilog/tms_pkg.sv */
// Purpose: Constants and types of the touch digitizer sequencer
// Assumes: Wishbone register map on 32-bit aligned words
// Notes: Shared by the sequencer, its property checks and the bench
package tms_pkg;

   // --------------------------------------------------------------
   // Conversion geometry
   // --------------------------------------------------------------
   localparam int TMS_RES_BITS = 12; // Full resolution
   localparam int TMS_LO_BITS = 8; // Reduced resolution
   localparam int TMS_CODE_STEPS = 4096; // Codes across the span
   localparam int TMS_CMD_BITS = 8; // Control word length
   localparam int TMS_TRACK_EDGE = 5; // Falling edge that opens track
   localparam int TMS_ACQ_CYCLES = 3; // Track window in serial cycles
   localparam logic [11:0] TMS_FULL_MASK = 12'hFFF;
   localparam logic [11:0] TMS_LO_MASK = 12'hFF0;
   localparam logic [11:0] TMS_MSB_ONE = 12'h800;

   // --------------------------------------------------------------
   // Command fields
   // --------------------------------------------------------------
   localparam logic [2:0] TMS_CH_XP = 3'h1;
   localparam logic [2:0] TMS_CH_AUXA = 3'h2;
   localparam logic [2:0] TMS_CH_YP = 3'h5;
   localparam logic [2:0] TMS_CH_AUXB = 3'h6;
   localparam logic [1:0] TMS_PD_AWAKE = 2'h3;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam logic [7:0] TMS_OFF_CFG = 8'h00;
   localparam logic [7:0] TMS_OFF_STAT = 8'h04;
   localparam logic [7:0] TMS_OFF_RESULT = 8'h08;
   localparam logic [7:0] TMS_OFF_IDENT = 8'h0C;
   localparam logic TMS_CFG_EN_RST = 1'b1; // Serial port enabled

   // --------------------------------------------------------------
   // Types
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      TMS_ST_IDLE, TMS_ST_CMD, TMS_ST_ACQ, TMS_ST_CONV, TMS_ST_PUSH
   } tms_state_e;
   typedef enum logic [2:0] {
      TMS_MUX_NONE, TMS_MUX_XP, TMS_MUX_YP, TMS_MUX_AUXA, TMS_MUX_AUXB
   } tms_mux_e;
   typedef enum logic [1:0] {
      TMS_REF_PIN, TMS_REF_YPAIR, TMS_REF_XPAIR
   } tms_ref_e;

endpackage

/* verilog/tms_sequencer.sv */
// Purpose: Serial command decode, track/convert sequencing and
//          result shift-out of a touch digitizer, with Wishbone regs
// Assumes: Serial pins are asynchronous to clk_sys and much slower
// Notes: Result words pass a two-entry buffer before shift-out

// ------------------------------------------------------------------
// Small buffer
// ------------------------------------------------------------------
module tms_fifo #(
   parameter int W = 13,
   parameter int D = 2
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   generate
      if (D < 2) begin : g_bad_depth
         $error("tms_fifo needs a depth of at least two");
      end
   endgenerate

   logic [W-1:0] mem_q [D]; // Entry storage
   logic [AW-1:0] wr_q; // Write index
   logic [AW-1:0] rd_q; // Read index
   logic [CW-1:0] cnt_q; // Entries held
   logic push;
   logic pop;

   // Full and empty come straight from the count
   assign in_ready = (cnt_q != CW'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count; flush drops stale words
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule

// ------------------------------------------------------------------
// Sequencer top
// ------------------------------------------------------------------
module tms_sequencer
   import tms_pkg::*;
#(
   parameter logic [11:0] IDENT_CODE = 12'h5A3 // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cs_n_pin,
   input wire logic serial_conv_clock,
   input wire logic din_pin,
   input wire logic cmp_hi,
   output logic [11:0] sar_trial,
   output logic dout,
   output logic dout_oe_n,
   output logic busy_o,
   output logic busy_oe_n,
   output logic track_o,
   output tms_mux_e mux_sel,
   output tms_ref_e ref_sel,
   output logic x_drv_on,
   output logic y_drv_on,
   output logic pwr_down
);

   // --------------------------------------------------------------
   // Pin synchronisers and edge detection
   // --------------------------------------------------------------
   logic [3:0] sy1_q; // First stage, read only by second stage
   logic [3:0] sy2_q; // Second stage: cs, clock, data, comparator
   logic sck_prev_q; // Clock level one cycle back
   logic cs_s, sck_s, din_s, cmp_s, rise, fall, active;

   // Two flops per pin; deselected and idle-low clock at reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= 4'h8;
         sy2_q <= 4'h8;
         sck_prev_q <= 1'b0;
      end else begin
         sy1_q <= {cs_n_pin, serial_conv_clock, din_pin, cmp_hi};
         sy2_q <= sy1_q;
         sck_prev_q <= sy2_q[2];
      end
   end

   assign cs_s = sy2_q[3];
   assign sck_s = sy2_q[2];
   assign din_s = sy2_q[1];
   assign cmp_s = sy2_q[0];
   // Every step of the sequence but the push waits for a serial clock edge
   assign rise = sck_s & ~sck_prev_q;
   assign fall = ~sck_s & sck_prev_q;

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   logic cfg_en_q; // Software enable of the serial port
   logic [7:0] cmd_word_q; // Control word as shifted in; full once decoded
   logic [12:0] word_q; // Resolution flag and result code
   tms_state_e state_q;
   logic [2:0] bitcnt_q; // Command bits taken after the start
   logic [3:0] fcnt_q; // Falling edges since the start bit
   logic [11:0] mask_q; // Bit under trial
   logic [3:0] step_q; // Decisions made
   logic [11:0] sh_q; // Output shift register
   logic [3:0] shn_q; // Result bits still to send
   logic ack_q;
   logic [7:0] wcmd;
   logic [11:0] trial_nx;
   logic [3:0] nbits;
   logic last_step, hold_edge, fifo_rdy, fifo_vld, pop_rdy;
   logic [12:0] fifo_data;

   // Deselect or disable abandons any word in flight
   assign active = ~cs_s & cfg_en_q;
   assign wcmd = {1'b1, cmd_word_q[5:0], din_s};
   assign nbits = word_q[12] ? 4'(TMS_LO_BITS) : 4'(TMS_RES_BITS);
   assign last_step = (step_q == nbits - 4'h1);
   assign hold_edge = fall && fcnt_q == 4'(TMS_TRACK_EDGE
                      + TMS_ACQ_CYCLES - 1);
   // Keep the trial bit when input is above, then try the next
   assign trial_nx = (cmp_s ? sar_trial : sar_trial & ~mask_q)
                     | (mask_q >> 1);

   // --------------------------------------------------------------
   // Command and conversion sequence
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TMS_ST_IDLE;
         bitcnt_q <= 3'h0;
         cmd_word_q <= 8'h00;
      end else if (!active) begin
         state_q <= TMS_ST_IDLE;
      end else begin
         unique case (state_q)
            // Zeros before the start bit are ignored
            TMS_ST_IDLE: begin
               if (rise && din_s) begin
                  state_q <= TMS_ST_CMD;
                  bitcnt_q <= 3'h0;
               end
            end
            // Seven more bits, MSB first, on rising edges
            TMS_ST_CMD: begin
               if (rise) begin
                  cmd_word_q <= {cmd_word_q[6:0], din_s};
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == 3'(TMS_CMD_BITS - 2)) begin
                     cmd_word_q <= wcmd;
                     state_q <= TMS_ST_ACQ;
                  end
               end
            end
            // Hold ends acquisition; identity skips conversion
            TMS_ST_ACQ: begin
               if (hold_edge) begin
                  if (cmd_word_q[6:4] == TMS_CH_AUXB && !cmd_word_q[2])
                     begin
                     state_q <= TMS_ST_PUSH;
                  end else begin
                     state_q <= TMS_ST_CONV;
                  end
               end
            end
            // One decision per rising edge
            TMS_ST_CONV: begin
               if (rise && last_step) begin
                  state_q <= TMS_ST_PUSH;
               end
            end
            // Stalls here while the buffer is full
            TMS_ST_PUSH: begin
               if (fifo_rdy) begin
                  state_q <= TMS_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Falling edge count from the start bit, saturating
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fcnt_q <= 4'h0;
      end else if (state_q == TMS_ST_IDLE) begin
         fcnt_q <= 4'h0;
      end else if (fall && fcnt_q != 4'hF) begin
         fcnt_q <= fcnt_q + 4'h1;
      end
   end

   // Track from the fifth falling edge for three cycles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         track_o <= 1'b0;
      end else if (!active || hold_edge) begin
         track_o <= 1'b0;
      end else if (fall && fcnt_q == 4'(TMS_TRACK_EDGE - 1)
                   && state_q != TMS_ST_IDLE) begin
         track_o <= 1'b1;
      end
   end

   // Successive approximation and result word
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sar_trial <= 12'h000;
         mask_q <= 12'h000;
         step_q <= 4'h0;
         word_q <= 13'h0000;
      end else if (state_q == TMS_ST_ACQ && hold_edge) begin
         sar_trial <= TMS_MSB_ONE;
         mask_q <= TMS_MSB_ONE;
         step_q <= 4'h0;
         word_q <= {cmd_word_q[3], IDENT_CODE};
      end else if (state_q == TMS_ST_CONV && rise) begin
         sar_trial <= trial_nx;
         mask_q <= mask_q >> 1;
         step_q <= step_q + 4'h1;
         if (last_step) begin
            word_q[11:0] <= trial_nx & (word_q[12] ? TMS_LO_MASK
                            : TMS_FULL_MASK);
         end
      end
   end

   // --------------------------------------------------------------
   // Multiplexer, drivers, reference and power
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mux_sel <= TMS_MUX_NONE;
         ref_sel <= TMS_REF_PIN;
         x_drv_on <= 1'b0;
         y_drv_on <= 1'b0;
         pwr_down <= 1'b1;
      end else if (active && state_q == TMS_ST_CMD && rise
                   && bitcnt_q == 3'(TMS_CMD_BITS - 2)) begin
         pwr_down <= 1'b0;
         mux_sel <= TMS_MUX_NONE;
         ref_sel <= TMS_REF_PIN;
         x_drv_on <= 1'b0;
         y_drv_on <= 1'b0;
         // Invalid codes leave input, drivers and pair reference off, power on
         unique case (wcmd[6:4])
            TMS_CH_XP: begin
               mux_sel <= TMS_MUX_XP;
               y_drv_on <= 1'b1;
               if (!wcmd[2]) ref_sel <= TMS_REF_YPAIR;
            end
            TMS_CH_YP: begin
               mux_sel <= TMS_MUX_YP;
               x_drv_on <= 1'b1;
               if (!wcmd[2]) ref_sel <= TMS_REF_XPAIR;
            end
            TMS_CH_AUXA: begin
               if (wcmd[2]) mux_sel <= TMS_MUX_AUXA;
            end
            TMS_CH_AUXB: begin
               if (wcmd[2]) mux_sel <= TMS_MUX_AUXB;
            end
            default: begin
               mux_sel <= TMS_MUX_NONE;
            end
         endcase
      end else if (state_q == TMS_ST_PUSH && fifo_rdy
                   && cmd_word_q[1:0] != TMS_PD_AWAKE) begin
         // Drivers stay on until a command lets them go
         x_drv_on <= 1'b0;
         y_drv_on <= 1'b0;
         mux_sel <= TMS_MUX_NONE;
         ref_sel <= TMS_REF_PIN; // Pair reference ends with the drivers
         pwr_down <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Result buffer and output shifter
   // --------------------------------------------------------------
   assign pop_rdy = fall & ~cs_s & (shn_q == 4'h0);

   tms_fifo #(.W(13), .D(2)) u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .flush(cs_s),
      .in_valid(state_q == TMS_ST_PUSH),
      .in_data(word_q),
      .in_ready(fifo_rdy),
      .out_valid(fifo_vld),
      .out_data(fifo_data),
      .out_ready(pop_rdy)
   );

   // Bits change only on falling edges or deselect; zeros once a word is spent
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 12'h000;
         shn_q <= 4'h0;
         dout <= 1'b0;
      end else if (cs_s) begin
         shn_q <= 4'h0;
         dout <= 1'b0;
      end else if (fall) begin
         if (shn_q != 4'h0) begin
            dout <= sh_q[11];
            sh_q <= sh_q << 1;
            shn_q <= shn_q - 4'h1;
         end else if (fifo_vld) begin
            dout <= fifo_data[11];
            sh_q <= fifo_data[11:0] << 1;
            shn_q <= (fifo_data[12] ? 4'(TMS_LO_BITS)
                      : 4'(TMS_RES_BITS)) - 4'h1;
         end else begin
            dout <= 1'b0;
         end
      end
   end

   // Output enables follow chip select; busy marks conversion
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dout_oe_n <= 1'b1;
         busy_oe_n <= 1'b1;
         busy_o <= 1'b0;
      end else begin
         dout_oe_n <= cs_s;
         busy_oe_n <= cs_s;
         busy_o <= (state_q == TMS_ST_CONV);
      end
   end

   // --------------------------------------------------------------
   // Wishbone slave
   // --------------------------------------------------------------
   // Answer one cycle after the request; ack drops the cycle after
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         cfg_en_q <= TMS_CFG_EN_RST;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            unique case (wb_adr_i)
               TMS_OFF_CFG: wb_dat_o <= {31'h0, cfg_en_q};
               TMS_OFF_STAT: wb_dat_o <= {20'h0, track_o, fifo_vld,
                  pwr_down, busy_o, cmd_word_q};
               TMS_OFF_RESULT: wb_dat_o <= {19'h0, word_q};
               TMS_OFF_IDENT: wb_dat_o <= {20'h0, IDENT_CODE};
               default: wb_dat_o <= 32'h0000_0000; // Unmapped
            endcase
            // Write lands at the edge that takes the request
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == TMS_OFF_CFG) begin
               cfg_en_q <= wb_dat_i[0];
            end
         end
      end
   end
endmodule
